// File: rtl/smdc_defines.svh
// Contract
// - Standard: ten-bit cylinder on tag bus, TAG1.
// - Standard drive returns exactly one status byte.
// - Extended: 20-bit cylinder via TAG1 and TAG4.
// - Extended: 20-bit head over tag bus.
// - Extended: unit select plus TAG4 picks status.
// - Five variants with 1,4,1,16,7 status bytes.
// - Per-drive variant and data rate kept.
// - Modified: TAG4 and TAG5 select four bytes.
`ifndef SMDC_DEFINES_SVH
`define SMDC_DEFINES_SVH

`define SMDC_CLK_MHZ        20
`define SMDC_SETUP_NS       100
`define SMDC_STROBE_NS      500
`define SMDC_HOLD_NS        100
`define SMDC_SETUP_CYC      ((`SMDC_SETUP_NS * `SMDC_CLK_MHZ + 999) / 1000)
`define SMDC_STROBE_CYC     ((`SMDC_STROBE_NS * `SMDC_CLK_MHZ + 999) / 1000)
`define SMDC_HOLD_CYC       ((`SMDC_HOLD_NS * `SMDC_CLK_MHZ + 999) / 1000)
`define SMDC_NSTAT_STD      5'h01
`define SMDC_NSTAT_MOD      5'h04
`define SMDC_NSTAT_ENH      5'h01
`define SMDC_NSTAT_EXT      5'h10
`define SMDC_NSTAT_E        5'h07
`define SMDC_NDRIVE         16
`define SMDC_TAG_CYL        4'h1
`define SMDC_TAG_HEAD       4'h2
`define SMDC_TAG_CTL        4'h3
`define SMDC_TAG_HI         4'h4

`endif

// File: rtl/smdc_pkg.sv
package smdc_pkg;
  typedef enum logic [2:0] {
    SMDC_STD, SMDC_MOD, SMDC_ENH, SMDC_EXT, SMDC_E
  } smdc_var_e;
  typedef enum logic [1:0] {
    SMDC_CMD_CYL, SMDC_CMD_HEAD, SMDC_CMD_CTL, SMDC_CMD_STAT
  } smdc_cmd_e;
  typedef enum {
    SMDC_IDLE, SMDC_SETUP, SMDC_STROBE, SMDC_HOLD
  } smdc_st_e;
endpackage

// File: rtl/smdc_port.sv
`timescale 1ns/1ps
`include "smdc_defines.svh"

module smdc_port
  import smdc_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_CFG_WE,
  input  wire logic [3:0]  I_CFG_DRIVE,
  input  wire logic [2:0]  I_CFG_VARIANT,
  input  wire logic [1:0]  I_CFG_RATE,
  input  wire logic        I_REQ,
  input  wire logic [3:0]  I_DRIVE,
  input  wire logic [1:0]  I_CMD,
  input  wire logic [19:0] I_VALUE,
  input  wire logic [3:0]  I_STAT_SEL,
  input  wire logic [7:0]  I_STATUS,
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic             O_ERR,
  output logic [7:0]       O_STATUS,
  output logic [2:0]       O_VARIANT,
  output logic [1:0]       O_RATE,
  output logic             O_DEV_SEL_EN,
  output logic [3:0]       O_DEV_SEL,
  output logic             O_TAG1,
  output logic             O_TAG2,
  output logic             O_TAG3,
  output logic             O_TAG4,
  output logic             O_TAG5,
  output logic [9:0]       O_TAG_BUS,
  output logic             O_IF_EN
);

  localparam logic [3:0] SETUP_C  = 4'(`SMDC_SETUP_CYC);
  localparam logic [3:0] STROBE_C = 4'(`SMDC_STROBE_CYC);
  localparam logic [3:0] HOLD_C   = 4'(`SMDC_HOLD_CYC);

  typedef struct packed {
    smdc_st_e   st;
    logic [3:0] cnt;
    logic       second;
    logic [3:0] drv;
    logic [1:0] cmd;
    logic [19:0] val;
    logic [3:0] sel;
    logic       sel_en;
    logic [3:0] sel_ln;
    logic [4:0] tags;
    logic [9:0] bus;
    logic       busy;
    logic       done;
    logic       err;
    logic [7:0] status;
  } smdc_s;

  smdc_s s_q;
  smdc_s s_d;

  // Per-drive variant and rate; mixed drives on one cable work side by side.
  logic [2:0] var_q  [`SMDC_NDRIVE];
  logic [1:0] rate_q [`SMDC_NDRIVE];

  genvar gi;
  generate
    for (gi = 0; gi < `SMDC_NDRIVE; gi++) begin : g_drv
      always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
          var_q[gi]  <= 3'h0;
          rate_q[gi] <= 2'h0;
        end else if (I_CFG_WE && I_CFG_DRIVE == 4'(gi)) begin
          var_q[gi]  <= I_CFG_VARIANT;
          rate_q[gi] <= I_CFG_RATE;
        end
      end
    end
  endgenerate

  logic [2:0] req_var;
  logic [4:0] nstat;
  logic       is_ext;
  logic       is_mod;
  logic       is_enh;

  always_comb begin
    req_var = var_q[I_DRIVE];
    case (smdc_var_e'(req_var))
      SMDC_MOD: nstat = `SMDC_NSTAT_MOD;
      SMDC_ENH: nstat = `SMDC_NSTAT_ENH;
      SMDC_EXT: nstat = `SMDC_NSTAT_EXT;
      SMDC_E:   nstat = `SMDC_NSTAT_E;
      default:  nstat = `SMDC_NSTAT_STD;
    endcase
  end

  assign is_ext = (smdc_var_e'(var_q[s_q.drv]) == SMDC_EXT);
  assign is_mod = (smdc_var_e'(var_q[s_q.drv]) == SMDC_MOD);
  assign is_enh = (smdc_var_e'(var_q[s_q.drv]) == SMDC_ENH);

  // ==========================================================================
  // Transfer sequencer
  // ==========================================================================
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      SMDC_IDLE: begin
        s_d.tags   = 5'h00;
        s_d.sel_en = 1'b0;
        if (I_REQ) begin
          // A refused index never reaches the cable; O_ERR stands until the next accepted request.
          if ({1'b0, I_STAT_SEL} >= nstat && smdc_cmd_e'(I_CMD) == SMDC_CMD_STAT) begin
            s_d.err  = 1'b1;
            s_d.done = 1'b1;
          end else begin
            s_d.err    = 1'b0;
            s_d.drv    = I_DRIVE;
            s_d.cmd    = I_CMD;
            s_d.val    = I_VALUE;
            s_d.sel    = I_STAT_SEL;
            s_d.second = 1'b0;
            s_d.busy   = 1'b1;
            s_d.cnt    = SETUP_C;
            s_d.st     = SMDC_SETUP;
          end
        end
      end
      SMDC_SETUP: begin
        // Bus and select lines settle before any strobe rises.
        s_d.sel_en = 1'b1;
        s_d.sel_ln = s_q.drv;
        case (smdc_cmd_e'(s_q.cmd))
          SMDC_CMD_CYL:  s_d.bus = s_q.second ? s_q.val[19:10] : s_q.val[9:0];
          SMDC_CMD_HEAD: s_d.bus = s_q.second ? s_q.val[19:10] : s_q.val[9:0];
          SMDC_CMD_CTL:  s_d.bus = s_q.val[9:0];
          default:       s_d.bus = 10'h000;
        endcase
        if (smdc_cmd_e'(s_q.cmd) == SMDC_CMD_STAT && (is_ext || is_mod)) begin
          s_d.sel_ln = s_q.sel;
        end
        if (smdc_cmd_e'(s_q.cmd) == SMDC_CMD_CYL && is_enh) begin
          s_d.bus = s_q.val[9:0];
        end
        if (s_q.cnt <= 4'h1) begin
          s_d.cnt = STROBE_C;
          s_d.st  = SMDC_STROBE;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      SMDC_STROBE: begin
        // Tag bus is not touched here, so it stays stable under the strobe.
        case (smdc_cmd_e'(s_q.cmd))
          SMDC_CMD_CYL:  s_d.tags = s_q.second ? 5'h08 : 5'h01;
          SMDC_CMD_HEAD: s_d.tags = s_q.second ? 5'h08 : 5'h02;
          SMDC_CMD_CTL:  s_d.tags = 5'h04;
          default: begin
            if (is_ext) begin
              s_d.tags = 5'h08;
            end else if (is_mod) begin
              s_d.tags = {1'b1, 1'b1, 3'h0};
            end else begin
              s_d.tags = 5'h00;
            end
          end
        endcase
        if (s_q.cnt <= 4'h1) begin
          s_d.status = I_STATUS;
          s_d.cnt    = HOLD_C;
          s_d.st     = SMDC_HOLD;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      SMDC_HOLD: begin
        s_d.tags = 5'h00;
        if (s_q.cnt <= 4'h1) begin
          if (!s_q.second && is_ext && (smdc_cmd_e'(s_q.cmd) == SMDC_CMD_CYL
              || smdc_cmd_e'(s_q.cmd) == SMDC_CMD_HEAD)) begin
            s_d.second = 1'b1;
            s_d.cnt    = SETUP_C;
            s_d.st     = SMDC_SETUP;
          end else begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st   = SMDC_IDLE;
          end
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: s_d.st = SMDC_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      s_q <= '{st: SMDC_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign O_BUSY       = s_q.busy;
  assign O_DONE       = s_q.done;
  assign O_ERR        = s_q.err;
  assign O_STATUS     = s_q.status;
  assign O_VARIANT    = var_q[I_CFG_DRIVE];
  assign O_RATE       = rate_q[I_CFG_DRIVE];
  assign O_DEV_SEL_EN = s_q.sel_en;
  assign O_DEV_SEL    = s_q.sel_ln;
  assign O_TAG1       = s_q.tags[0];
  assign O_TAG2       = s_q.tags[1];
  assign O_TAG3       = s_q.tags[2];
  assign O_TAG4       = s_q.tags[3];
  assign O_TAG5       = s_q.tags[4];
  assign O_TAG_BUS    = s_q.bus;
  assign O_IF_EN      = ~I_RST;

endmodule // smdc_port

// File: tb/smdc_drive_model.sv
`timescale 1ns/1ps
// ====
// Drive side: the byte names the selected unit or status index.
module smdc_drive_model (
  input  wire logic       i_sel_en,
  input  wire logic [3:0] i_sel,
  output logic [7:0]      o_status
);
  // A deselected cable floats, so show a pattern rather than the last byte.
  assign o_status = i_sel_en ? {4'ha, i_sel} : 8'h5a;
endmodule // smdc_drive_model

// File: tb/smdc_port_monitor.sv
`timescale 1ns/1ps
// ====
// Cable timing checks.
module smdc_port_monitor (
  input wire logic       I_SYS_CLK,
  input wire logic       I_RST,
  input wire logic       I_REQ,
  input wire logic       O_BUSY,
  input wire logic       O_DONE,
  input wire logic       O_ERR,
  input wire logic       O_DEV_SEL_EN,
  input wire logic       O_TAG1,
  input wire logic       O_TAG2,
  input wire logic       O_TAG3,
  input wire logic       O_TAG4,
  input wire logic       O_TAG5,
  input wire logic [9:0] O_TAG_BUS,
  input wire logic       O_IF_EN
);
  logic t;
  assign t = O_TAG1 | O_TAG2 | O_TAG3 | O_TAG4 | O_TAG5;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  a_bus_stable: assert property (t && $past(t) |-> $stable(O_TAG_BUS))
    else $error("tag bus moved during a strobe");
  a_setup_gap: assert property ($rose(t) |-> $past(O_DEV_SEL_EN, 2))
    else $error("strobe without select setup");
  a_strobe_len: assert property ($rose(t) |-> t[*8] ##1 t ##1 t ##1 !t)
    else $error("strobe length wrong");
  a_one_tag: assert property (O_TAG1 |-> !O_TAG4 && !O_TAG2)
    else $error("cylinder strobe overlaps another");
  a_tag_sel: assert property (t |-> O_DEV_SEL_EN)
    else $error("strobe with select disabled");
  a_req_done: assert property (I_REQ && !O_BUSY |-> ##[1:30] O_DONE)
    else $error("request never completed");
  a_err_done: assert property ($rose(O_ERR) |-> O_DONE)
    else $error("refusal without done");
  a_pair_five: assert property (O_TAG5 |-> O_TAG4)
    else $error("fifth tag alone");
  a_if_en: assert property (disable iff (1'b0) O_IF_EN != I_RST)
    else $error("interface enable wrong");
  cover property ($rose(O_TAG4));
  cover property ($rose(O_TAG5));
  cover property ($rose(O_ERR));
endmodule // smdc_port_monitor

// File: tb/tb_top.sv
`timescale 1ns/1ps
// ====
// Transfers per variant, compared with the strobes seen on the cable.
module tb_top;
  import smdc_pkg::*;
  typedef struct packed {
    logic [3:0] d; logic [1:0] c; logic [19:0] v; logic [3:0] s;
    logic [1:0] n; logic [14:0] f; logic [14:0] l; logic [7:0] st; logic e;
  } smdc_row_s;
  logic        clk = 1'b0, rst = 1'b1, we = 1'b0, req = 1'b0;
  logic [3:0]  cdrv = 4'h0, drv = 4'h0, sel = 4'h0, dsel;
  logic [2:0]  cvar = 3'h0, ovar;
  logic [1:0]  crate = 2'h0, cmd = 2'h0, orate;
  logic [19:0] val = 20'h0;
  logic [7:0]  stat, o_st;
  logic        busy, done, err, sen, t1, t2, t3, t4, t5, ifen;
  logic [9:0]  bus;
  logic [4:0]  tags, ptags = 5'h0;
  logic [14:0] first, last;
  int          n_errors = 0, n_tests = 0, nstr = 0;
  smdc_row_s   rows [13] = '{
    '{4'h0, 2'h0, 20'h003ff, 4'h0, 2'h1, 15'h07ff, 15'h07ff, 8'h00, 1'b0},
    '{4'h3, 2'h0, 20'habcde, 4'h0, 2'h2, 15'h04de, 15'h22af, 8'h00, 1'b0},
    '{4'h3, 2'h1, 20'h12345, 4'h0, 2'h2, 15'h0b45, 15'h2048, 8'h00, 1'b0},
    '{4'h3, 2'h3, 20'h00000, 4'hf, 2'h1, 15'h2000, 15'h2000, 8'haf, 1'b0},
    '{4'h1, 2'h3, 20'h00000, 4'h3, 2'h1, 15'h6000, 15'h6000, 8'ha3, 1'b0},
    '{4'h4, 2'h3, 20'h00000, 4'h7, 2'h0, 15'h0000, 15'h0000, 8'h00, 1'b1},
    '{4'h0, 2'h3, 20'h00000, 4'h1, 2'h0, 15'h0000, 15'h0000, 8'h00, 1'b1},
    '{4'h0, 2'h3, 20'h00000, 4'h0, 2'h0, 15'h0000, 15'h0000, 8'ha0, 1'b0},
    '{4'h0, 2'h2, 20'h00155, 4'h0, 2'h1, 15'h1155, 15'h1155, 8'h00, 1'b0},
    '{4'h2, 2'h0, 20'hfffff, 4'h0, 2'h1, 15'h07ff, 15'h07ff, 8'h00, 1'b0},
    '{4'h2, 2'h3, 20'h00000, 4'h1, 2'h0, 15'h0000, 15'h0000, 8'h00, 1'b1},
    '{4'h4, 2'h3, 20'h00000, 4'h6, 2'h0, 15'h0000, 15'h0000, 8'ha4, 1'b0},
    '{4'h1, 2'h3, 20'h00000, 4'h4, 2'h0, 15'h0000, 15'h0000, 8'h00, 1'b1}};
  always #25 clk = ~clk;
  assign tags = {t5, t4, t3, t2, t1};
  smdc_port dut (.I_SYS_CLK(clk), .I_RST(rst), .I_CFG_WE(we), .I_CFG_DRIVE(cdrv),
    .I_CFG_VARIANT(cvar), .I_CFG_RATE(crate), .I_REQ(req), .I_DRIVE(drv), .I_CMD(cmd),
    .I_VALUE(val), .I_STAT_SEL(sel), .I_STATUS(stat),
    .O_BUSY(busy), .O_DONE(done), .O_ERR(err), .O_STATUS(o_st), .O_VARIANT(ovar),
    .O_RATE(orate), .O_DEV_SEL_EN(sen), .O_DEV_SEL(dsel), .O_TAG1(t1), .O_TAG2(t2),
    .O_TAG3(t3), .O_TAG4(t4), .O_TAG5(t5), .O_TAG_BUS(bus), .O_IF_EN(ifen));
  smdc_drive_model u_drive (.i_sel_en(sen), .i_sel(dsel), .o_status(stat));
  // Sampling off the active edge keeps the record free of update races.
  always @(negedge clk) begin
    if (tags != 5'h0 && ptags == 5'h0) begin
      nstr++;
      if (nstr == 1) first = {tags, bus};
      last = {tags, bus};
    end
    ptags = tags;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input smdc_row_s r);
    int k;
    @(negedge clk);
    nstr = 0;
    drv = r.d; cmd = r.c; val = r.v; sel = r.s; req = 1'b1;
    @(negedge clk) req = 1'b0;
    for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk);
    chk(20'(k < 40), 20'h1);
    chk(20'(nstr), 20'(r.n));
    if (r.n != 2'h0) begin
      chk({first[14:10], last[14:10]}, {r.f[14:10], r.l[14:10]});
      if (r.c != 2'h3) chk({first[9:0], last[9:0]}, {r.f[9:0], r.l[9:0]});
    end
    if (r.c == 2'h3 && !r.e) chk(20'(o_st), 20'(r.st));
    chk(20'(err), 20'(r.e));
  endtask
  task automatic results;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(20'({busy, done, err, ifen, ovar}), 20'h00008);
    for (int i = 0; i < 5; i++) begin
      cdrv = 4'(i); cvar = 3'(i); crate = 2'(i); we = 1'b1;
      @(negedge clk) we = 1'b0;
      @(negedge clk) chk(20'({ovar, orate}), 20'({cvar, crate}));
    end
    foreach (rows[i]) run(rows[i]);
    // A request while busy is ignored, so only the first transfer reaches the cable.
    @(negedge clk);
    nstr = 0;
    drv = 4'h0;
    cmd = 2'h2;
    val = 20'h00155;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
    repeat (4) @(negedge clk);
    drv = 4'h3;
    cmd = 2'h0;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
    repeat (20) @(negedge clk);
    chk(20'(nstr), 20'h00001);
    chk(20'(first), 20'h01155);
    chk(20'(busy), 20'h00000);
    // Reset in the middle of a strobe must clear the cable and the drive table.
    val = 20'habcde;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
    repeat (6) @(negedge clk);
    chk(20'(tags), 20'h00001);
    rst = 1'b1;
    @(negedge clk);
    chk(20'({ifen, tags, sen}), 20'h00000);
    @(negedge clk) rst = 1'b0;
    @(negedge clk);
    chk(20'({busy, done, err, sen, tags, ifen, ovar}), 20'h00008);
    run(rows[0]);
    results;
  end
  initial begin
    #150000;
    n_errors++;
    results;
  end
endmodule // tb_top
bind smdc_port smdc_port_monitor u_mon (.I_SYS_CLK, .I_RST, .I_REQ, .O_BUSY, .O_DONE,
  .O_ERR, .O_DEV_SEL_EN, .O_TAG1, .O_TAG2, .O_TAG3, .O_TAG4, .O_TAG5, .O_TAG_BUS, .O_IF_EN);
